// *** core/wwdt_consts.svh ***
`ifndef WWDT_CONSTS_SVH
`define WWDT_CONSTS_SVH

// ****************
// register map
// ****************
`define WWDT_OFF_CTRL 12'h000
`define WWDT_OFF_RELOAD 12'h004
`define WWDT_OFF_WINDOW 12'h008
`define WWDT_OFF_SERVICE 12'h00C
`define WWDT_OFF_TIMER 12'h010
`define WWDT_OFF_STATUS 12'h014
`define WWDT_OFF_MASK 12'h018

// ****************
// fields
// ****************
`define WWDT_CTRL_ENABLE 0
`define WWDT_CTRL_RATE 1
`define WWDT_CTRL_WINDOW 2
`define WWDT_CTRL_DBG_RUN 3
`define WWDT_SERVICE_KEY 8'hA5
`define WWDT_ST_OVF 0
`define WWDT_ST_EARLY 1
`define WWDT_ST_RESET 2

// ****************
// timing and reset values
// ****************
`define WWDT_DIV_SLOW 7'h7F
`define WWDT_DIV_FAST 7'h01
`define WWDT_PREWARN_COUNTS 8'h30
`define WWDT_CTRL_RESET 4'h0
`define WWDT_RELOAD_RESET 8'h00
`define WWDT_WINDOW_RESET 8'h00

`endif

// *** core/wwdt_pkg.sv ***
package wwdt_pkg;
    typedef enum logic [1:0] {
        WWDT_IDLE = 2'b00,
        WWDT_RUN = 2'b01,
        WWDT_PREWARN = 2'b10,
        WWDT_FIRED = 2'b11
    } wwdt_state_t;

    typedef struct packed {
        logic enable;
        logic count_rate_select;
        logic window_enable;
        logic debug_run;
    } wwdt_ctrl_t;

    typedef struct packed {
        logic sys_reset;
        logic early;
        logic overflow;
    } wwdt_events_t;
endpackage

// *** core/wwdt_prescaler.sv ***
`timescale 1ns/100ps
`include "wwdt_consts.svh"

// ****************
// tick generator: one pulse per pclk/2 or pclk/128
// ****************
module wwdt_prescaler (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic run,
    input wire logic count_rate_select,
    input wire logic restart,
    // tick out
    output logic tick
);
    logic [6:0] div_cnt;
    wire [6:0] div_top;
    wire div_wrap;

    assign div_top = count_rate_select ? `WWDT_DIV_SLOW
                                       : `WWDT_DIV_FAST;
    assign div_wrap = run && (div_cnt >= div_top);
    assign tick = div_wrap;

    // restart keeps the first period after service full length
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 7'h00;
        end else if (restart || div_wrap) begin
            div_cnt <= 7'h00;
        end else if (run) begin
            div_cnt <= div_cnt + 7'h01;
        end
    end
endmodule

// *** core/wwdt_top.sv ***
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/100ps
`include "wwdt_consts.svh"

module wwdt_top (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // system
    input wire logic debug_mode,
    output logic timeout_nmi_request,
    output logic watchdog_system_reset,
    output logic irq
);
    // ****************
    // state
    // ****************
    wwdt_pkg::wwdt_ctrl_t ctrl;
    wwdt_pkg::wwdt_state_t state;
    wwdt_pkg::wwdt_events_t status;
    wwdt_pkg::wwdt_events_t mask;
    logic [7:0] upper_byte_reload;
    logic [7:0] window_bound_high_byte;
    logic [15:0] supervision_timer;
    logic [7:0] prewarn_cnt;

    // ****************
    // bus decode
    // ****************
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire rd = acc && !pwrite;
    wire hit_ctrl = (paddr == `WWDT_OFF_CTRL);
    wire hit_rel = (paddr == `WWDT_OFF_RELOAD);
    wire hit_win = (paddr == `WWDT_OFF_WINDOW);
    wire hit_svc = (paddr == `WWDT_OFF_SERVICE);
    wire hit_tmr = (paddr == `WWDT_OFF_TIMER);
    wire hit_st = (paddr == `WWDT_OFF_STATUS);
    wire hit_msk = (paddr == `WWDT_OFF_MASK);
    wire mapped = hit_ctrl | hit_rel | hit_win | hit_svc | hit_tmr
                | hit_st | hit_msk;

    assign pready = 1'b1;
    assign pslverr = acc && !mapped;

    // a service is a write of the key; single cycle strobe
    wire service = wr && hit_svc
                && (pwdata[7:0] == `WWDT_SERVICE_KEY);

    // ****************
    // counting
    // ****************
    wire running = (state == wwdt_pkg::WWDT_RUN)
                || (state == wwdt_pkg::WWDT_PREWARN);
    wire frozen = debug_mode && !ctrl.debug_run;
    wire tick;

    wwdt_prescaler u_pre (
        .pclk(pclk),
        .presetn(presetn),
        .run(running && !frozen),
        .count_rate_select(ctrl.count_rate_select),
        .restart(service && state == wwdt_pkg::WWDT_RUN),
        .tick(tick)
    );

    // chained bytes: carry out of the low byte steps the high byte
    wire low_carry = tick && (supervision_timer[7:0] == 8'hFF);
    wire [7:0] next_low = supervision_timer[7:0] + 8'h01;
    wire [7:0] next_high = supervision_timer[15:8] + 8'h01;
    wire overflow = low_carry && (supervision_timer[15:8] == 8'hFF);

    // timer below bound:00 is forbidden for refresh
    wire in_window = ctrl.window_enable
                  && (supervision_timer < {window_bound_high_byte, 8'h00});
    wire early = service && in_window
              && (state == wwdt_pkg::WWDT_RUN);
    wire valid_svc = service && !in_window;
    wire ovf_evt = overflow && (state == wwdt_pkg::WWDT_RUN);
    wire prewarn_done = (state == wwdt_pkg::WWDT_PREWARN) && tick
                     && (prewarn_cnt == `WWDT_PREWARN_COUNTS - 8'h01);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            supervision_timer <= 16'h0000;
        end else if (wr && hit_ctrl && pwdata[`WWDT_CTRL_ENABLE]
                     && state == wwdt_pkg::WWDT_IDLE) begin
            supervision_timer <= {upper_byte_reload, 8'h00};
        end else if (valid_svc && state == wwdt_pkg::WWDT_RUN) begin
            supervision_timer <= {upper_byte_reload, 8'h00};
        end else if (low_carry) begin
            supervision_timer <= {next_high, 8'h00};
        end else if (tick) begin
            supervision_timer <= {supervision_timer[15:8], next_low};
        end
    end

    // ****************
    // state machine
    // ****************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= wwdt_pkg::WWDT_IDLE;
            prewarn_cnt <= 8'h00;
        end else begin
            case (state)
                wwdt_pkg::WWDT_IDLE: begin
                    if (wr && hit_ctrl && pwdata[`WWDT_CTRL_ENABLE]) begin
                        state <= wwdt_pkg::WWDT_RUN;
                    end
                end
                wwdt_pkg::WWDT_RUN: begin
                    prewarn_cnt <= 8'h00;
                    if (ovf_evt || early) begin
                        state <= wwdt_pkg::WWDT_PREWARN;
                    end
                end
                wwdt_pkg::WWDT_PREWARN: begin
                    // service ignored here: reset cannot be cancelled
                    if (prewarn_done) begin
                        state <= wwdt_pkg::WWDT_FIRED;
                    end else if (tick) begin
                        prewarn_cnt <= prewarn_cnt + 8'h01;
                    end
                end
                wwdt_pkg::WWDT_FIRED: begin
                    state <= wwdt_pkg::WWDT_FIRED;
                end
                default: begin
                    state <= wwdt_pkg::WWDT_IDLE;
                end
            endcase
        end
    end

    // requests stay high until presetn takes the system down
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timeout_nmi_request <= 1'b0;
            watchdog_system_reset <= 1'b0;
        end else begin
            if (ovf_evt) begin
                timeout_nmi_request <= 1'b1;
            end
            if (prewarn_done) begin
                watchdog_system_reset <= 1'b1;
            end
        end
    end

    // ****************
    // registers
    // ****************
    wire st_read = rd && hit_st;
    wwdt_pkg::wwdt_events_t evt;
    assign evt = '{sys_reset: prewarn_done, early: early, overflow: ovf_evt};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `WWDT_CTRL_RESET;
            upper_byte_reload <= `WWDT_RELOAD_RESET;
            window_bound_high_byte <= `WWDT_WINDOW_RESET;
            mask <= 3'b000;
            status <= 3'b000;
        end else begin
            if (wr && hit_ctrl) begin
                ctrl.enable <= pwdata[`WWDT_CTRL_ENABLE] | ctrl.enable;
                ctrl.count_rate_select <= pwdata[`WWDT_CTRL_RATE];
                ctrl.window_enable <= pwdata[`WWDT_CTRL_WINDOW];
                ctrl.debug_run <= pwdata[`WWDT_CTRL_DBG_RUN];
            end
            if (wr && hit_rel) begin
                upper_byte_reload <= pwdata[7:0];
            end
            if (wr && hit_win) begin
                window_bound_high_byte <= pwdata[7:0];
            end
            if (wr && hit_msk) begin
                mask <= pwdata[2:0];
            end
            // set wins over read-clear; clear only what the read reported,
            // so an event one cycle before the access edge is not lost
            status <= (st_read ? (status & ~prdata[2:0]) : status) | evt;
        end
    end

    assign irq = |(status & mask);

    // ****************
    // read data
    // ****************
    wire [31:0] rd_ctrl = {28'h000_0000, ctrl.debug_run, ctrl.window_enable,
                           ctrl.count_rate_select, ctrl.enable};
    wire [31:0] rd_tmr = {14'h0000, state, supervision_timer};
    wire [31:0] next_prdata = hit_ctrl ? rd_ctrl
                            : hit_rel ? {24'h00_0000, upper_byte_reload}
                            : hit_win ? {24'h00_0000, window_bound_high_byte}
                            : hit_tmr ? rd_tmr
                            : hit_st ? {29'h0000_0000, status}
                            : hit_msk ? {29'h0000_0000, mask}
                            : 32'h0000_0000;

    // data registered at the setup cycle, valid through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= next_prdata;
        end
    end
endmodule

// *** tb/wwdt_properties.sv ***
`timescale 1ns/100ps
`include "wwdt_consts.svh"

module wwdt_props (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // system
    input wire logic debug_mode,
    input wire logic timeout_nmi_request,
    input wire logic watchdog_system_reset,
    input wire logic irq
);
    logic wacc;
    logic svc;
    logic [3:0] ctrl;
    logic [7:0] reload;
    logic early;
    logic [12:0] since_nmi;
    assign wacc = psel && penable && pready && pwrite;
    assign svc = wacc && paddr == `WWDT_OFF_SERVICE
        && pwdata[7:0] == `WWDT_SERVICE_KEY;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `WWDT_CTRL_RESET;
            reload <= `WWDT_RELOAD_RESET;
            early <= 1'b0;
            since_nmi <= '0;
        end else begin
            // enable is sticky in hardware
            if (wacc && paddr == `WWDT_OFF_CTRL)
                ctrl <= pwdata[3:0] | {3'b000, ctrl[0]};
            if (wacc && paddr == `WWDT_OFF_RELOAD)
                reload <= pwdata[7:0];
            // permissive: timer value is not visible here
            if (svc && ctrl[2])
                early <= 1'b1;
            if (timeout_nmi_request && !watchdog_system_reset)
                since_nmi <= since_nmi + 13'd1;
        end
    end

    // ****************
    // properties
    // ****************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_open_service;
        svc && ctrl[0] && !ctrl[2] && !early && !timeout_nmi_request;
    endsequence
    sequence s_timer_read;
        psel && !penable && !pwrite && paddr == `WWDT_OFF_TIMER
            ##1 psel && penable;
    endsequence

    AST_RELOAD: assert property (
        s_open_service ##1 s_timer_read |-> prdata[17:8] == {2'b01, reload}
        && prdata[7:0] <= 8'h01) else $error("no reload");
    AST_NMI_HELD: assert property (
        timeout_nmi_request |=> timeout_nmi_request) else $error("nmi drop");
    AST_RST_HELD: assert property (
        watchdog_system_reset |=> watchdog_system_reset)
        else $error("reset drop");
    AST_NMI_CAUSE: assert property (
        $rose(timeout_nmi_request) |-> ctrl[0] && !watchdog_system_reset)
        else $error("stray nmi");
    AST_RST_CAUSE: assert property (
        $rose(watchdog_system_reset) |-> timeout_nmi_request || early)
        else $error("stray reset");
    AST_PREWARN_LEN: assert property (
        $rose(watchdog_system_reset) && timeout_nmi_request && !ctrl[1]
        |-> since_nmi >= 13'd93 && since_nmi <= 13'd99)
        else $error("prewarning length");
    AST_FROZEN: assert property (
        debug_mode && $past(debug_mode) && $past(debug_mode, 2) && !ctrl[3]
        |-> !$rose(timeout_nmi_request) && !$rose(watchdog_system_reset))
        else $error("ran in debug");
    AST_READY: assert property (
        psel && penable |-> pready
        && pslverr == (paddr > `WWDT_OFF_MASK || paddr[1:0] != 2'b00))
        else $error("access stalled or wrong error flag");
endmodule

bind wwdt_top wwdt_props u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .debug_mode(debug_mode),
    .timeout_nmi_request(timeout_nmi_request),
    .watchdog_system_reset(watchdog_system_reset), .irq(irq)
);

// *** tb/wwdt_top_bench.sv ***
`timescale 1ns/100ps
`include "wwdt_consts.svh"

`define CK(g, e) begin n_compared++; if ((g) !== (e)) begin \
    n_errors++; $display("BAD %0t %h %h", $time, g, e); end end

module wwdt_top_bench;
    localparam logic [31:0] KEY = 32'h0000_00A5;
    logic pclk = 1'b0, presetn = 1'b0, debug_mode = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, nmi, sys_rst, irq;
    logic [15:0] dt;
    int n_errors = 0, n_compared = 0, cycles = 0, k;

    wwdt_top dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .debug_mode(debug_mode),
        .timeout_nmi_request(nmi), .watchdog_system_reset(sys_rst),
        .irq(irq)
    );

    always #2 pclk = ~pclk;
    // the tests need about 6000 cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("TB: %0d bad of %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    // keep leaves psel up so the next setup follows at once
    task automatic bus(input logic wr, input logic [11:0] a,
            input logic [31:0] d, input logic keep);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        penable <= 1'b0;
        if (!keep) begin
            psel <= 1'b0;
            @(posedge pclk);
        end
    endtask

    task automatic rdr(input logic [11:0] a);
        bus(1'b0, a, 32'h0000_0000, 1'b0);
    endtask

    // timer advance over 256 pclk cycles
    task automatic span();
        rdr(`WWDT_OFF_TIMER);
        dt = rd[15:0];
        repeat (253) @(posedge pclk);
        rdr(`WWDT_OFF_TIMER);
        dt = rd[15:0] - dt;
    endtask

    task automatic wait_for(input logic on_rst, input int lim);
        k = 0;
        while ((on_rst ? sys_rst : nmi) !== 1'b1 && k < lim) begin
            @(posedge pclk);
            k++;
        end
    endtask

    initial begin
        do_reset();
        rdr(`WWDT_OFF_RELOAD);
        `CK(rd, 32'h0000_0000)
        rdr(12'h01C);
        `CK({err, rd}, 33'h1_0000_0000)
        $display("test access done");
        bus(1'b1, `WWDT_OFF_WINDOW, 32'h0000_00F8, 1'b0);
        bus(1'b1, `WWDT_OFF_RELOAD, 32'h0000_00F0, 1'b0);
        bus(1'b1, `WWDT_OFF_CTRL, 32'h0000_0001, 1'b0);
        repeat (40) @(posedge pclk);
        bus(1'b1, `WWDT_OFF_SERVICE, KEY, 1'b1);
        rdr(`WWDT_OFF_TIMER);
        `CK(rd[17:8], 10'h1F0)
        `CK(rd[7:1], 7'h00)
        span();
        `CK(dt >= 16'd127 && dt <= 16'd129, 1'b1)
        bus(1'b1, `WWDT_OFF_CTRL, 32'h0000_0003, 1'b0);
        span();
        `CK(dt >= 16'd1 && dt <= 16'd3, 1'b1)
        debug_mode <= 1'b1;
        span();
        `CK(dt, 16'h0000)
        // debug_run lets the timer keep counting in debug
        bus(1'b1, `WWDT_OFF_CTRL, 32'h0000_000B, 1'b0);
        span();
        `CK(dt >= 16'd1 && dt <= 16'd3, 1'b1)
        debug_mode <= 1'b0;
        $display("test count done");
        bus(1'b1, `WWDT_OFF_SERVICE, KEY, 1'b0);
        bus(1'b1, `WWDT_OFF_MASK, 32'h0000_0002, 1'b0);
        bus(1'b1, `WWDT_OFF_CTRL, 32'h0000_0005, 1'b0);
        repeat (4200) @(posedge pclk);
        rdr(`WWDT_OFF_TIMER);
        `CK(rd[15:8], 8'hF8)
        bus(1'b1, `WWDT_OFF_SERVICE, KEY, 1'b1);
        rdr(`WWDT_OFF_TIMER);
        `CK(rd[17:8], 10'h1F0)
        bus(1'b1, `WWDT_OFF_SERVICE, KEY, 1'b0);
        `CK(irq, 1'b1)
        rdr(`WWDT_OFF_TIMER);
        `CK({nmi, rd[17:16]}, 3'b010)
        rdr(`WWDT_OFF_STATUS);
        `CK({irq, rd[2:0]}, 4'b0010)
        `CK(irq, 1'b0)
        wait_for(1'b1, 200);
        `CK({sys_rst, nmi}, 2'b10)
        $display("test window done");
        do_reset();
        bus(1'b1, `WWDT_OFF_RELOAD, 32'h0000_00FF, 1'b0);
        bus(1'b1, `WWDT_OFF_MASK, 32'h0000_0001, 1'b0);
        bus(1'b1, `WWDT_OFF_CTRL, 32'h0000_0001, 1'b0);
        wait_for(1'b0, 600);
        `CK(k >= 500 && k <= 520, 1'b1)
        `CK({irq, sys_rst}, 2'b10)
        bus(1'b1, `WWDT_OFF_SERVICE, KEY, 1'b0);
        wait_for(1'b1, 200);
        `CK(k >= 86 && k <= 98, 1'b1)
        rdr(`WWDT_OFF_STATUS);
        `CK({nmi, rd[2:0]}, 4'b1101)
        $display("test overflow done");
        complete_run();
    end
endmodule
